// >>> dv/otgc_link_model.sv
// Link controller model that makes register accesses on its own clock.
`timescale 1ns/100ps
module otgc_link_model (
  input  wire logic       mclk,      // Drive timing.
  input  wire logic [7:0] reg_rdata, // Read data.
  output logic            link_clk,  // Link clock.
  output logic            reg_wr,    // Write strobe.
  output logic            reg_rd,    // Read strobe.
  output logic [5:0]      reg_addr,  // Address.
  output logic [7:0]      reg_wdata  // Write data.
);
  // The link clock runs free; the odd offset keeps its phase unrelated to mclk.
  initial begin
    {link_clk, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    #37;
    forever #200 link_clk = ~link_clk;
  end
  // Strobe set half a link period ahead of the rise so the synchronised copies agree.
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge link_clk);
    @(negedge mclk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
    @(posedge link_clk);
    repeat (6) @(negedge mclk);
    q = reg_rdata;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule // otgc_link_model

// >>> dv/otgc_props.sv
// Port checker for the line control and edge enable bank.
`timescale 1ns/100ps
module otgc_props import otgc_pkg::*; (
  input wire logic                 mclk,          // Clock.
  input wire logic                 sys_rst,       // Reset.
  input wire logic                 reg_wr,        // Write strobe.
  input wire logic                 reg_rd,        // Read strobe.
  input wire logic [7:0]           reg_rdata,     // Read data.
  input wire otgc_pkg::otgc_src_t  comp_in,       // Sources.
  input wire logic                 host_mode,     // Host mode.
  input wire otgc_pkg::otgc_line_t line_ctl,      // Line outputs.
  input wire logic                 bus_valid_out, // Valid level.
  input wire logic                 irq_event      // Event pulse.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [3:0] quiet;
  logic [3:0] wr_quiet;
  // Cycles since the write strobe was last high; a write to the valid select may also make an edge.
  always_ff @(posedge mclk) begin
    if (sys_rst || reg_wr)
      wr_quiet <= 4'h0;
    else if (wr_quiet != 4'hF)
      wr_quiet <= wr_quiet + 4'h1;
  end
  // Cycles since a source or the mode last moved; events must follow a move closely.
  always_ff @(posedge mclk) begin
    if (sys_rst || comp_in != $past(comp_in) || host_mode != $past(host_mode))
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  sequence s_no_wr; !reg_wr [*8]; endsequence
  sequence s_no_rd; !reg_rd [*8]; endsequence
  property p_line_rst; $fell(sys_rst) |-> line_ctl == 6'h18; endproperty
  property p_out_rst; $fell(sys_rst) |-> reg_rdata == 8'h00 && !irq_event; endproperty
  property p_pulse; irq_event |=> !irq_event; endproperty
  property p_line_hold; s_no_wr |=> $stable(line_ctl); endproperty
  property p_rd_hold; s_no_rd |=> $stable(reg_rdata); endproperty
  property p_valid; comp_in.bus_valid [*6] |-> bus_valid_out; endproperty
  property p_valid_hold; (!comp_in.bus_valid && !reg_wr) [*8] |=> $stable(bus_valid_out); endproperty
  property p_irq_cause; irq_event |-> (quiet < 4'hA && quiet > 4'h1) || wr_quiet < 4'h3; endproperty
  a_line_rst: assert property (p_line_rst) else $error("line outputs wrong after reset");
  a_out_rst: assert property (p_out_rst) else $error("outputs not clear after reset");
  a_pulse: assert property (p_pulse) else $error("event longer than one cycle");
  a_line_hold: assert property (p_line_hold) else $error("line outputs moved without write");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  a_valid: assert property (p_valid) else $error("valid low with comparator high");
  a_valid_hold: assert property (p_valid_hold) else $error("valid moved without cause");
  a_irq_cause: assert property (p_irq_cause) else $error("event without source edge");
endmodule // otgc_props
bind otgc_bank otgc_props i_otgc_props (.mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .comp_in(comp_in), .host_mode(host_mode), .line_ctl(line_ctl),
  .bus_valid_out(bus_valid_out), .irq_event(irq_event));

// >>> dv/tb.sv
// Self-checking bench for the line control and edge enable bank.
`timescale 1ns/100ps
module tb;
  import otgc_pkg::*;
  logic       mclk = 1'b0, sys_rst = 1'b1, host_mode = 1'b1, link_clk, reg_wr, reg_rd, bus_valid_out, irq_event;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, d, e, v[3];
  logic [31:0] seed = 32'h6096FAC1;
  otgc_src_t  comp_in = '0;
  otgc_line_t line_ctl;
  int         error_cnt = 0, n_compared = 0, cyc = 0, irqs = 0;
  otgc_bank i_otgc_bank (.mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .comp_in(comp_in), .host_mode(host_mode),
    .line_ctl(line_ctl), .bus_valid_out(bus_valid_out), .irq_event(irq_event));
  otgc_link_model u_link (.mclk(mclk), .reg_rdata(reg_rdata), .link_clk(link_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  always #25 mclk = ~mclk;
  // Counts events and cuts a hang short; the tests need about thirteen hundred and fifty cycles.
  always @(posedge mclk) begin
    cyc++;
    irqs += irq_event;
    if (cyc == 4000) begin
      error_cnt++;
      stop_test();
    end
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Write, set and clear; the mask keeps read-only bits at zero.
  function automatic logic [7:0] exp_op(logic [7:0] o, logic [7:0] x, int op, logic [7:0] m);
    return op == 0 ? x & m : op == 1 ? o | (x & m) : o & ~x;
  endfunction
  function automatic otgc_line_t line_of(logic [7:0] x);
    return {x[0], x[1], x[2], x[3], x[4], x[5] | x[6]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence: reset values, register operations, edge events, host gating, status masking.
  initial begin
    repeat (20) @(posedge mclk);
    @(negedge mclk) sys_rst = 1'b0;
    check(8'(line_ctl), 8'h18);
    for (int r = 0; r < 3; r++) begin
      v[r] = r ? EDGE_EN_RST : OTG_CTRL_RST;
      u_link.xfer(1'b0, 6'(10 + 3 * r), 8'h00, rd);
      check(rd, v[r]);
      for (int k = 0; k < 9; k++) begin
        d = k == 0 ? 8'hFF : xs();
        u_link.xfer(1'b1, 6'(10 + 3 * r + k % 3), d, rd);
        v[r] = exp_op(v[r], d, k % 3, r ? EDGE_EN_MASK : 8'hFF);
        u_link.xfer(1'b0, 6'(10 + 3 * r + (k + 1) % 3), 8'h00, rd);
        check(rd, v[r]);
        if (r == 0) check(8'(line_ctl), 8'(line_of(v[0])));
        if (r == 0) check(8'(bus_valid_out), 8'(v[0][7]));
      end
    end
    // Back to the internal comparator, so the bus-valid source makes edges of its own below.
    u_link.xfer(1'b1, OTG_CTRL_CLR, 8'h80, rd);
    v[0] = v[0] & 8'h7F;
    u_link.xfer(1'b0, OTG_CTRL_WR, 8'h00, rd);
    check(rd, v[0]);
    check(8'(bus_valid_out), 8'h00);
    u_link.xfer(1'b0, IRQ_LATCH_ADDR, 8'h00, rd);
    for (int k = 0; k < 10; k++) begin
      @(negedge mclk) comp_in[k % 5] = ~comp_in[k % 5];
      irqs = 0;
      repeat (12) @(negedge mclk);
      e = 8'(comp_in[k % 5] ? v[1][k % 5] : v[2][k % 5]);
      check(8'(irqs), e);
      u_link.xfer(1'b0, IRQ_LATCH_ADDR, 8'h00, rd);
      check(rd, e << (k % 5));
    end
    u_link.xfer(1'b1, RISE_EN_SET, 8'h03, rd);
    u_link.xfer(1'b1, FALL_EN_SET, 8'h03, rd);
    // Out of host mode the disconnect source stays silent both ways, even with its enables set.
    @(negedge mclk) host_mode = 1'b0;
    comp_in.host_disconnect = 1'b1;
    irqs = 0;
    repeat (12) @(negedge mclk);
    check(8'(irqs), 8'h00);
    u_link.xfer(1'b0, IRQ_STATUS_ADDR, 8'h00, rd);
    check(rd, 8'h00);
    comp_in.host_disconnect = 1'b0;
    repeat (6) @(negedge mclk);
    host_mode = 1'b1;
    u_link.xfer(1'b0, IRQ_LATCH_ADDR, 8'h00, rd);
    check(rd, 8'h00);
    check(8'(irqs), 8'h00);
    @(negedge mclk) comp_in.bus_valid = 1'b1;
    u_link.xfer(1'b0, IRQ_STATUS_ADDR, 8'h00, rd);
    check(rd, 8'h00);
    u_link.xfer(1'b1, FALL_EN_CLR, 8'h02, rd);
    u_link.xfer(1'b0, IRQ_STATUS_ADDR, 8'h00, rd);
    check(rd, 8'h02);
    u_link.xfer(1'b0, 6'h3F, 8'h00, rd);
    check(rd, 8'h00);
    stop_test();
  end
endmodule // tb

// >>> include/otgc_pkg.sv
// Package with register map, reset values and field layouts of the line control and edge enable bank.
package otgc_pkg;

  localparam int         ADDR_W          = 6;
  localparam logic [5:0] OTG_CTRL_WR     = 6'h0A;
  localparam logic [5:0] OTG_CTRL_SET    = 6'h0B;
  localparam logic [5:0] OTG_CTRL_CLR    = 6'h0C;
  localparam logic [5:0] RISE_EN_WR      = 6'h0D;
  localparam logic [5:0] RISE_EN_SET     = 6'h0E;
  localparam logic [5:0] RISE_EN_CLR     = 6'h0F;
  localparam logic [5:0] FALL_EN_WR      = 6'h10;
  localparam logic [5:0] FALL_EN_SET     = 6'h11;
  localparam logic [5:0] FALL_EN_CLR     = 6'h12;
  localparam logic [5:0] IRQ_STATUS_ADDR = 6'h13;
  localparam logic [5:0] IRQ_LATCH_ADDR  = 6'h14;

  localparam logic [7:0] OTG_CTRL_RST    = 8'h06;
  localparam logic [7:0] EDGE_EN_RST     = 8'h1F;
  localparam logic [7:0] EDGE_EN_MASK    = 8'h1F;

  localparam int         NUM_SRC         = 5;
  localparam int         SRC_HOST_DISC   = 0;
  localparam int         SRC_BUS_VALID   = 1;
  localparam int         SRC_SESS_VALID  = 2;
  localparam int         SRC_SESS_END    = 3;
  localparam int         SRC_ID_GND      = 4;

  // Register access operation decoded from the address.
  typedef enum logic [1:0] {
    OTGC_OP_WRITE,
    OTGC_OP_SET,
    OTGC_OP_CLEAR
  } otgc_op_t;

  // Line control outputs towards the analog front end.
  typedef struct packed {
    logic id_pin_pullup_enable;
    logic plus_line_pulldown_enable;
    logic minus_line_pulldown_enable;
    logic bus_power_discharge_enable;
    logic bus_power_charge_enable;
    logic bus_power_drive_req;
  } otgc_line_t;

  // Comparator sources as seen by the edge logic.
  typedef struct packed {
    logic id_grounded;
    logic session_end;
    logic session_valid;
    logic bus_valid;
    logic host_disconnect;
  } otgc_src_t;

endpackage

// >>> rtl/otgc_bank.sv
// Line control and edge-selective interrupt enable register bank on the link register port.
`timescale 1ns/100ps
module otgc_bank (
  input  wire logic                   mclk,          // System clock, 20 MHz.
  input  wire logic                   sys_rst,       // Synchronous reset, active high.
  input  wire logic                   link_clk,      // Link clock pin, sampled here.
  input  wire logic                   reg_wr,        // Register write strobe, link domain, held over a link edge.
  input  wire logic                   reg_rd,        // Register read strobe, link domain, held over a link edge.
  input  wire logic [5:0]             reg_addr,      // Register address.
  input  wire logic [7:0]             reg_wdata,     // Write data.
  output logic      [7:0]             reg_rdata,     // Read data, registered.
  input  wire otgc_pkg::otgc_src_t    comp_in,       // Raw comparator levels.
  input  wire logic                   host_mode,     // High while acting as host.
  output otgc_pkg::otgc_line_t        line_ctl,      // Line control outputs.
  output logic                        bus_valid_out, // Selected bus power valid level.
  output logic                        irq_event      // One-cycle interrupt notification.
);
  import otgc_pkg::*;

  logic [7:0] otg_line_control;
  logic [7:0] irq_rise_enable;
  logic [7:0] irq_fall_enable;
  logic [7:0] irq_latch;
  logic [2:0] clk_sync;
  logic [5:0] acc_addr_meta;
  logic [5:0] acc_addr;
  logic [7:0] wr_byte_meta;
  logic [7:0] wr_byte;
  logic [1:0] wr_sync;
  logic [1:0] rd_sync;
  logic [NUM_SRC-1:0] src_meta;
  logic [NUM_SRC-1:0] src_sync;
  logic [NUM_SRC-1:0] src_prev;
  logic [NUM_SRC-1:0] src_live;
  logic [NUM_SRC-1:0] rise_hit;
  logic [NUM_SRC-1:0] fall_hit;
  logic [NUM_SRC-1:0] ev_hit;
  logic               link_rise;
  logic               wr_go;
  logic               rd_go;
  logic               ext_valid_indicator_in;

  // The external indicator is tied high inside this device.
  assign ext_valid_indicator_in = 1'b1;

  // Pin inputs pass two flip-flops; the third stage of the clock only feeds edge detection.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clk_sync <= 3'h0;
      wr_sync  <= 2'h0;
      rd_sync  <= 2'h0;
      src_meta <= '0;
      src_sync <= '0;
      src_prev <= '0;
    end else begin
      clk_sync <= {clk_sync[1:0], link_clk};
      wr_sync  <= {wr_sync[0], reg_wr};
      rd_sync  <= {rd_sync[0], reg_rd};
      src_meta <= comp_in;
      src_sync <= src_meta;
      src_prev <= src_live;
    end
  end

  // Address and data cross through two flip-flops in step with the strobes, so both are settled at the take.
  // They hold still for the whole strobe, which is what makes a plain double flop safe for a multi-bit word.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc_addr_meta <= 6'h00;
      acc_addr      <= 6'h00;
      wr_byte_meta  <= 8'h00;
      wr_byte       <= 8'h00;
    end else begin
      acc_addr_meta <= reg_addr;
      acc_addr      <= acc_addr_meta;
      wr_byte_meta  <= reg_wdata;
      wr_byte       <= wr_byte_meta;
    end
  end

  // Strobes are acted upon once per link clock rising edge.
  assign link_rise = clk_sync[1] & ~clk_sync[2];
  assign wr_go     = link_rise & wr_sync[1];
  assign rd_go     = link_rise & rd_sync[1];

  // Bus-valid follows the external indicator when selected; host-disconnect only counts in host mode.
  always_comb begin
    src_live = src_sync;
    src_live[SRC_BUS_VALID] = otg_line_control[7] ? ext_valid_indicator_in : src_sync[SRC_BUS_VALID];
    src_live[SRC_HOST_DISC] = host_mode & src_sync[SRC_HOST_DISC];
  end

  // Write, set and clear share one helper so all three registers behave alike.
  function automatic logic [7:0] apply_op(input logic [7:0] cur, input logic [7:0] d, input otgc_op_t op);
    case (op)
      OTGC_OP_WRITE: apply_op = d;
      OTGC_OP_SET:   apply_op = cur | d;
      OTGC_OP_CLEAR: apply_op = cur & ~d;
      default:       apply_op = cur;
    endcase
  endfunction

  // Line control register; every bit is plain read, write, set and clear.
  // The output pins follow it directly, so a write shows on them at the same edge that takes it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      otg_line_control <= OTG_CTRL_RST;
    end else if (wr_go) begin
      case (acc_addr)
        OTG_CTRL_WR:  otg_line_control <= apply_op(otg_line_control, wr_byte, OTGC_OP_WRITE);
        OTG_CTRL_SET: otg_line_control <= apply_op(otg_line_control, wr_byte, OTGC_OP_SET);
        OTG_CTRL_CLR: otg_line_control <= apply_op(otg_line_control, wr_byte, OTGC_OP_CLEAR);
        default:      otg_line_control <= otg_line_control;
      endcase
    end
  end

  // Edge enable registers; the upper three bits are masked off so they never hold a one.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_rise_enable <= EDGE_EN_RST;
      irq_fall_enable <= EDGE_EN_RST;
    end else if (wr_go) begin
      case (acc_addr)
        RISE_EN_WR:  irq_rise_enable <= apply_op(irq_rise_enable, wr_byte, OTGC_OP_WRITE) & EDGE_EN_MASK;
        RISE_EN_SET: irq_rise_enable <= apply_op(irq_rise_enable, wr_byte, OTGC_OP_SET) & EDGE_EN_MASK;
        RISE_EN_CLR: irq_rise_enable <= apply_op(irq_rise_enable, wr_byte, OTGC_OP_CLEAR) & EDGE_EN_MASK;
        FALL_EN_WR:  irq_fall_enable <= apply_op(irq_fall_enable, wr_byte, OTGC_OP_WRITE) & EDGE_EN_MASK;
        FALL_EN_SET: irq_fall_enable <= apply_op(irq_fall_enable, wr_byte, OTGC_OP_SET) & EDGE_EN_MASK;
        FALL_EN_CLR: irq_fall_enable <= apply_op(irq_fall_enable, wr_byte, OTGC_OP_CLEAR) & EDGE_EN_MASK;
        default: begin
          irq_rise_enable <= irq_rise_enable;
          irq_fall_enable <= irq_fall_enable;
        end
      endcase
    end
  end

  // Per-source edge qualification against the enables.
  // An edge is the live level against last cycle's, so a source select or mode change counts too.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_edge
      assign rise_hit[g] = src_live[g] & ~src_prev[g] & irq_rise_enable[g];
      assign fall_hit[g] = ~src_live[g] & src_prev[g] & irq_fall_enable[g];
      assign ev_hit[g]   = rise_hit[g] | fall_hit[g];
    end
  endgenerate

  // Latch: a new event in the read cycle survives, so set wins over the read clear.
  // Only the five source bits can ever be set; the upper three always read as zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_latch <= 8'h00;
    end else if (rd_go && acc_addr == IRQ_LATCH_ADDR) begin
      irq_latch <= {3'h0, ev_hit};
    end else begin
      irq_latch <= irq_latch | {3'h0, ev_hit};
    end
  end

  // Notification pulse to the link for enabled events only.
  // It is registered from the same hits, so it rises in the same cycle as the latch update and cannot glitch.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_event <= 1'b0;
    end else begin
      irq_event <= |ev_hit;
    end
  end

  // Read data is captured at the link edge that takes the read.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (rd_go) begin
      case (acc_addr)
        OTG_CTRL_WR, OTG_CTRL_SET, OTG_CTRL_CLR: reg_rdata <= otg_line_control;
        RISE_EN_WR, RISE_EN_SET, RISE_EN_CLR:    reg_rdata <= irq_rise_enable;
        FALL_EN_WR, FALL_EN_SET, FALL_EN_CLR:    reg_rdata <= irq_fall_enable;
        // The status byte shows the live levels at the moment of the take, with bus-valid read as zero while both its edge enables are set.
        IRQ_STATUS_ADDR: begin
          reg_rdata <= {3'h0, src_live};
          if (irq_rise_enable[SRC_BUS_VALID] && irq_fall_enable[SRC_BUS_VALID]) begin
            reg_rdata[SRC_BUS_VALID] <= 1'b0;
          end
        end
        IRQ_LATCH_ADDR:  reg_rdata <= irq_latch;
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  // Line control outputs are plain register bits, except the drive request, which is bit 5 or bit 6.
  always_comb begin
    line_ctl.id_pin_pullup_enable       = otg_line_control[0];
    line_ctl.plus_line_pulldown_enable  = otg_line_control[1];
    line_ctl.minus_line_pulldown_enable = otg_line_control[2];
    line_ctl.bus_power_discharge_enable = otg_line_control[3];
    line_ctl.bus_power_charge_enable    = otg_line_control[4];
    line_ctl.bus_power_drive_req        = otg_line_control[5] | otg_line_control[6];
  end

  // The selected valid level leaves the block straight from the source mux.
  assign bus_valid_out = src_live[SRC_BUS_VALID];

endmodule // otgc_bank
